// *** logic/cpg_timer.sv ***
// cascaded 16-bit pulse generator and warm-up timer with wishbone slave
//
// Summary of operation
// - two byte stages form one 16-bit up-counter on prescaled clock or pin.
// - pulse mode: count equals pulse width, invert flip-flop, keep counting.
// - pulse mode: count equals period, invert flip-flop, clear count, raise irq.
// - flip-flop loads start level from control bit; reset clears it to 0.
// - pulse pin shows inverse of the output flip-flop.
// - compare bytes take effect at once; software leaves them alone while running.
// - stopped counter holds pin; start level changed only after the stop.
// - warm-up mode compares only upper period byte against counter.
// - warm-up mode: after start, period match raises irq and clears count.
// - low warm-up spans 7.81 ms to 1.99 s at 32.768 kHz.
// - high warm-up spans 16 us to 4.08 ms.
`timescale 1ns/1ps
`default_nettype none
module cpg_timer (
    input wire logic mclk, // system clock, 125 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic count_input_pin, // external count pin
    output logic pulse_out_pin, // inverted flip-flop level
    output logic cascade_timer_irq // level interrupt
);
    cpg_tick_if tk ();

    logic [7:0] ctrl_ff;
    logic [7:0] pw_lo_ff;
    logic [7:0] pw_hi_ff;
    logic [7:0] per_lo_ff;
    logic [7:0] per_hi_ff;
    logic [7:0] status_ff;
    logic [7:0] mask_ff;
    logic [15:0] count_ff;
    logic oflop_ff;
    logic pin_ff;
    logic irq_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;

    logic req;
    logic wr;
    logic rd_status;
    logic run;
    logic warm;
    logic per_match;
    logic pw_match;
    logic step;
    logic per_event;
    logic [15:0] count_inc;

    cpg_tick_gen u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .count_input_pin(count_input_pin),
        .tk(tk)
    );

    assign tk.src = ctrl_ff[cpg_pkg::CTRL_SRC_HI:cpg_pkg::CTRL_SRC_LO];

    // bus: one wait state, ack for one cycle
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd_status = req & ~wb_we_i & (wb_adr_i == cpg_pkg::ADR_STATUS);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_comb begin
        nxt_rdat = 32'h00000000;
        unique case (wb_adr_i)
            cpg_pkg::ADR_CTRL: nxt_rdat[7:0] = ctrl_ff;
            cpg_pkg::ADR_PW_LO: nxt_rdat[7:0] = pw_lo_ff;
            cpg_pkg::ADR_PW_HI: nxt_rdat[7:0] = pw_hi_ff;
            cpg_pkg::ADR_PER_LO: nxt_rdat[7:0] = per_lo_ff;
            cpg_pkg::ADR_PER_HI: nxt_rdat[7:0] = per_hi_ff;
            cpg_pkg::ADR_STATUS: nxt_rdat[7:0] = status_ff;
            cpg_pkg::ADR_MASK: nxt_rdat[7:0] = mask_ff;
            cpg_pkg::ADR_COUNT: nxt_rdat[16:0] = {oflop_ff, count_ff};
            default: nxt_rdat = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_ff <= 32'h00000000;
        end else if (req) begin
            rdat_ff <= nxt_rdat;
        end else begin
            rdat_ff <= 32'h00000000;
        end
    end

    rdat_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");

    // control and mask
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= cpg_pkg::CTRL_RST;
            mask_ff <= cpg_pkg::BYTE_RST;
        end else if (wr && wb_adr_i == cpg_pkg::ADR_CTRL) begin
            ctrl_ff <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == cpg_pkg::ADR_MASK) begin
            mask_ff <= wb_dat_i[7:0];
        end
    end

    // compare bytes, live with no shadow copy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pw_lo_ff <= cpg_pkg::BYTE_RST;
            pw_hi_ff <= cpg_pkg::BYTE_RST;
            per_lo_ff <= cpg_pkg::BYTE_RST;
            per_hi_ff <= cpg_pkg::BYTE_RST;
        end else if (wr) begin
            unique case (wb_adr_i)
                cpg_pkg::ADR_PW_LO: pw_lo_ff <= wb_dat_i[7:0];
                cpg_pkg::ADR_PW_HI: pw_hi_ff <= wb_dat_i[7:0];
                cpg_pkg::ADR_PER_LO: per_lo_ff <= wb_dat_i[7:0];
                cpg_pkg::ADR_PER_HI: per_hi_ff <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    byte_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && wb_adr_i == cpg_pkg::ADR_PER_HI |=> per_hi_ff == $past(wb_dat_i[7:0]))
        else $error("period byte not stored at once");

    lane_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req && wb_we_i && !wb_sel_i[0] |=> $stable(ctrl_ff) && $stable(mask_ff))
        else $error("write with low lane off changed a register");

    assign run = ctrl_ff[cpg_pkg::CTRL_RUN];
    assign warm = ctrl_ff[cpg_pkg::CTRL_WARM];
    assign count_inc = count_ff + 16'h0001;
    // match on the value the count is about to take, so a period of n spans n ticks
    assign per_match = warm ? (count_inc[15:8] == per_hi_ff)
                            : (count_inc == {per_hi_ff, per_lo_ff});
    assign pw_match = count_inc == {pw_hi_ff, pw_lo_ff};
    assign step = run & tk.tick;
    assign per_event = step & per_match;

    // 16-bit cascaded up-counter, cleared while stopped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= cpg_pkg::COUNT_RST;
        end else if (!run) begin
            count_ff <= cpg_pkg::COUNT_RST;
        end else if (per_event) begin
            count_ff <= cpg_pkg::COUNT_RST;
        end else if (tk.tick) begin
            count_ff <= count_inc;
        end
    end

    // one upper step is 256 ticks, so 0100H gives 256 ticks of the count clock
    warm_span_a: assert property (@(posedge mclk) disable iff (!rst_n)
        per_event && warm && per_hi_ff != 8'h00
        |-> count_ff == {per_hi_ff, 8'h00} - 16'h0001)
        else $error("warm-up did not span 256 ticks per upper step");

    // output flip-flop: start level loads only on a write while stopped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oflop_ff <= cpg_pkg::FF_RST;
        end else if (wr && wb_adr_i == cpg_pkg::ADR_CTRL && !run) begin
            oflop_ff <= wb_dat_i[cpg_pkg::CTRL_INIT];
        end else if (step && !warm && (per_match || pw_match)) begin
            oflop_ff <= ~oflop_ff;
        end
    end

    warm_flop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        warm && !wr |=> $stable(oflop_ff))
        else $error("warm-up mode moved the output flip-flop");

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_ff <= ~cpg_pkg::FF_RST;
        end else begin
            pin_ff <= ~oflop_ff;
        end
    end

    // sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= cpg_pkg::BYTE_RST;
        end else if (per_event) begin
            status_ff[cpg_pkg::ST_PERIOD] <= 1'b1;
        end else if (rd_status) begin
            status_ff <= cpg_pkg::BYTE_RST;
        end
    end

    event_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        per_event |=> status_ff[cpg_pkg::ST_PERIOD])
        else $error("period event not latched in status");

    status_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        status_ff[cpg_pkg::ST_PERIOD] && !rd_status |=> status_ff[cpg_pkg::ST_PERIOD])
        else $error("status bit dropped without a read");

    status_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_status && !per_event |=> status_ff == 8'h00)
        else $error("status read did not clear");

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> cascade_timer_irq == $past(|(status_ff & mask_ff)))
        else $error("interrupt is not the masked status level");

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign pulse_out_pin = pin_ff;
    assign cascade_timer_irq = irq_ff;

    // checks
    localparam int IRQ_LAT = 2;

    per_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        per_event |=> count_ff == 16'h0000)
        else $error("period match did not clear counter");

    pw_toggle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step && !warm && pw_match && !per_match && !wr
        |=> oflop_ff != $past(oflop_ff) && count_ff == $past(count_ff) + 16'h0001)
        else $error("width match must toggle and keep counting");

    per_toggle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step && !warm && per_match && !wr |=> oflop_ff != $past(oflop_ff))
        else $error("period match did not toggle flip-flop");

    irq_path_a: assert property (@(posedge mclk) disable iff (!rst_n)
        per_event && mask_ff[0] |-> ##[1:IRQ_LAT] cascade_timer_irq)
        else $error("period event did not raise interrupt");

    pin_inv_a: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> pulse_out_pin == ~$past(oflop_ff))
        else $error("pin is not the inverse of the flip-flop");

    stop_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !run && !wr |=> $stable(oflop_ff) && count_ff == 16'h0000)
        else $error("stopped timer changed its output");

    init_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && wb_adr_i == cpg_pkg::ADR_CTRL && !run
        |=> oflop_ff == $past(wb_dat_i[cpg_pkg::CTRL_INIT]))
        else $error("start level not loaded");

    warm_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step && warm && count_inc[15:8] != per_hi_ff && !wr
        |=> count_ff == $past(count_ff) + 16'h0001 && $stable(oflop_ff))
        else $error("warm-up compared more than the upper byte");

    cascade_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        run && !tk.tick && !wr |=> $stable(count_ff))
        else $error("counter moved without a count tick");

    ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a single cycle");

    pulse_cycle_c: cover property (@(posedge mclk) disable iff (!rst_n)
        step && !warm && pw_match ##[1:1000] step && !warm && per_match);
    warm_done_c: cover property (@(posedge mclk) disable iff (!rst_n)
        per_event && warm);
    irq_read_c: cover property (@(posedge mclk) disable iff (!rst_n)
        cascade_timer_irq ##[1:20] rd_status);
    pin_count_c: cover property (@(posedge mclk) disable iff (!rst_n)
        step && tk.src == cpg_pkg::SRC_PIN);
    lane_off_c: cover property (@(posedge mclk) disable iff (!rst_n)
        req && wb_we_i && !wb_sel_i[0]);
endmodule // cpg_timer
`default_nettype wire

// *** logic/cpg_pkg.sv ***
// constants for the cascaded pulse generator and warm-up timer
`default_nettype none
package cpg_pkg;
    // register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_PW_LO = 8'h04;
    localparam logic [7:0] ADR_PW_HI = 8'h08;
    localparam logic [7:0] ADR_PER_LO = 8'h0C;
    localparam logic [7:0] ADR_PER_HI = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;
    localparam logic [7:0] ADR_MASK = 8'h18;
    localparam logic [7:0] ADR_COUNT = 8'h1C;
    // control and status bit positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_WARM = 1;
    localparam int CTRL_INIT = 2;
    localparam int CTRL_SRC_LO = 4;
    localparam int CTRL_SRC_HI = 5;
    localparam int ST_PERIOD = 0;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic FF_RST = 1'b0;
    // count sources: prescaled mclk or falling edge of the count pin
    localparam logic [1:0] SRC_DIV8 = 2'h0;
    localparam logic [1:0] SRC_DIV32 = 2'h1;
    localparam logic [1:0] SRC_DIV128 = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h3;
    localparam logic [6:0] DIV8_MASK = 7'h07;
    localparam logic [6:0] DIV32_MASK = 7'h1F;
    localparam logic [6:0] DIV128_MASK = 7'h7F;
    // warm-up intervals with the upper period byte at 01H and FFH
    localparam real LOW_CLK_KHZ = 32.768;
    localparam real WARM_LOW_MIN_MS = 7.81;
    localparam real WARM_LOW_MAX_S = 1.99;
    localparam real WARM_HIGH_MIN_US = 16.0;
    localparam real WARM_HIGH_MAX_MS = 4.08;
    // ticks per warm-up interval step of the upper byte
    localparam int WARM_STEP_TICKS = 256;
    localparam real CLK_MHZ = 125.0;
endpackage
`default_nettype wire

// *** logic/cpg_tick_if.sv ***
// count tick carrier between the tick generator and the timer core
`timescale 1ns/1ps
`default_nettype none
interface cpg_tick_if;
    logic [1:0] src;
    logic tick;
    modport gen (input src, output tick);
    modport core (output src, input tick);
endinterface
`default_nettype wire

// *** logic/cpg_tick_gen.sv ***
// count tick generator: mclk prescaler or count pin falling edge
`timescale 1ns/1ps
`default_nettype none
module cpg_tick_gen (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic count_input_pin, // external count pin
    cpg_tick_if.gen tk // tick to the core
);
    logic [6:0] pre_ff;
    logic pin_ff;
    logic tick_ff;
    logic nxt_tick;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= 7'h00;
        end else begin
            pre_ff <= pre_ff + 7'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_ff <= 1'b1;
        end else begin
            pin_ff <= count_input_pin;
        end
    end

    always_comb begin
        unique case (tk.src)
            cpg_pkg::SRC_DIV8: nxt_tick = (pre_ff & cpg_pkg::DIV8_MASK) == cpg_pkg::DIV8_MASK;
            cpg_pkg::SRC_DIV32: nxt_tick = (pre_ff & cpg_pkg::DIV32_MASK) == cpg_pkg::DIV32_MASK;
            cpg_pkg::SRC_DIV128: nxt_tick = pre_ff == cpg_pkg::DIV128_MASK;
            cpg_pkg::SRC_PIN: nxt_tick = pin_ff & ~count_input_pin;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    assign tk.tick = tick_ff;
endmodule // cpg_tick_gen
`default_nettype wire

// *** testbench/cpg_pin_src.sv ***
// external event source driving the count pin
`timescale 1ns/1ps
`default_nettype none
module cpg_pin_src (
    input wire logic mclk, // system clock
    output logic pin // count pin, idles high
);
    initial pin = 1'b1;
    task automatic emit(input int n);
        repeat (n) begin
            @(posedge mclk);
            pin <= 1'b0;
            repeat (3) @(posedge mclk);
            pin <= 1'b1;
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule // cpg_pin_src
`default_nettype wire

// *** testbench/tb_cascaded_pulse_gen_warmup_timer.sv ***
// self-checking bench for the cascaded pulse generator and warm-up timer
`timescale 1ns/1ps
`default_nettype none
module tb_cascaded_pulse_gen_warmup_timer;
    logic mclk;
    logic rst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic cpin;
    logic pout;
    logic irq;
    logic [31:0] q;
    logic [3:0] sel;
    logic [3:0] lane;
    int fail_count;
    int n_tests;
    int per;
    int pw;
    int n;
    int span;
    cpg_timer cpg_timer_i (
        .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .count_input_pin(cpin), .pulse_out_pin(pout), .cascade_timer_irq(irq)
    );
    cpg_pin_src cpg_pin_src_i (.mclk(mclk), .pin(cpin));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        sel <= lane;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k == 20) fail_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // flip-flop level expected for a count in pulse mode with start level 0
    function automatic logic exp_lvl(input logic [15:0] c, input int w);
        return c >= w;
    endfunction
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h00000000;
        sel = 4'h0;
        lane = 4'h1;
        rst_n = 1'b0;
        fail_count = 0;
        n_tests = 0;
        void'($urandom(32'h6d1cf4f3));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("pin", 32'h1, pout);
        chk("irq", 32'h0, irq);
        bus(0, cpg_pkg::ADR_COUNT, 8'h00);
        chk("count", 32'h0, q);
        bus(1, 8'h20, 8'hFF);
        bus(0, 8'h20, 8'h00);
        chk("unmapped", 32'h0, q);
        lane = 4'h0;
        bus(1, cpg_pkg::ADR_MASK, 8'h01);
        lane = 4'h1;
        bus(0, cpg_pkg::ADR_MASK, 8'h00);
        chk("lane off", 32'h0, q);
        bus(1, cpg_pkg::ADR_CTRL, 8'h04);
        bus(0, cpg_pkg::ADR_COUNT, 8'h00);
        chk("start level", 32'h10000, q);
        chk("pin", 32'h0, pout);
        for (int i = 0; i < 3; i++) begin
            per = 4 + $urandom % 9;
            pw = 1 + $urandom % (per - 1);
            bus(1, cpg_pkg::ADR_CTRL, 8'h00);
            repeat (2) @(posedge mclk);
            chk("pin", 32'h1, pout);
            bus(1, cpg_pkg::ADR_PW_LO, 8'(pw));
            bus(1, cpg_pkg::ADR_PW_HI, 8'h00);
            bus(1, cpg_pkg::ADR_PER_LO, 8'(per));
            bus(1, cpg_pkg::ADR_PER_HI, 8'h00);
            bus(1, cpg_pkg::ADR_MASK, (i != 0) ? 8'h01 : 8'h00);
            bus(1, cpg_pkg::ADR_CTRL, 8'h01);
            repeat (5) begin
                repeat ($urandom % 30) @(posedge mclk);
                bus(0, cpg_pkg::ADR_COUNT, 8'h00);
                chk("level", {31'h0, exp_lvl(q[15:0], pw)}, {31'h0, q[16]});
                chk("bound", 32'h1, {31'h0, q[15:0] < per});
            end
            if (i == 0) begin
                repeat (per * 24) @(posedge mclk);
                chk("masked irq", 32'h0, irq);
                bus(1, cpg_pkg::ADR_MASK, 8'h01);
                repeat (2) @(posedge mclk);
            end
            wait_irq(per * 16 + 40);
            chk("irq", 32'h1, irq);
            bus(1, cpg_pkg::ADR_CTRL, 8'h00);
            bus(0, cpg_pkg::ADR_COUNT, 8'h00);
            chk("stopped count", 32'h0, q & 32'hFFFF);
            repeat (20) @(posedge mclk);
            chk("held pin", {31'h0, ~q[16]}, pout);
            bus(0, cpg_pkg::ADR_STATUS, 8'h00);
            chk("status", 32'h1, q);
            bus(0, cpg_pkg::ADR_STATUS, 8'h00);
            chk("status clear", 32'h0, q);
            chk("irq clear", 32'h0, irq);
        end
        // lower period byte at 80H or more would add over 1000 cycles if used
        per = 32'h80 + $urandom % 128;
        bus(1, cpg_pkg::ADR_PER_LO, 8'(per));
        bus(1, cpg_pkg::ADR_PER_HI, 8'h01);
        bus(1, cpg_pkg::ADR_CTRL, 8'h03);
        // upper byte 01H: one step of ticks eight clocks apart, irq seen two edges late
        span = cpg_pkg::WARM_STEP_TICKS * (int'(cpg_pkg::DIV8_MASK) + 1);
        wait_irq(3000);
        chk("warm-up span", 32'h1, {31'h0, n >= span - 7 && n <= span + 1});
        bus(0, cpg_pkg::ADR_COUNT, 8'h00);
        chk("warm-up wrap", 32'h1, {31'h0, q[16:0] < 17'h00100});
        bus(1, cpg_pkg::ADR_CTRL, 8'h00);
        bus(0, cpg_pkg::ADR_STATUS, 8'h00);
        chk("warm-up status", 32'h1, q);
        bus(0, cpg_pkg::ADR_PER_LO, 8'h00);
        chk("period low", per, q);
        pw = 1 + $urandom % 6;
        bus(1, cpg_pkg::ADR_CTRL, 8'h31);
        cpg_pin_src_i.emit(pw);
        repeat (4) @(posedge mclk);
        bus(0, cpg_pkg::ADR_COUNT, 8'h00);
        chk("events", pw, q & 32'hFFFF);
        bus(1, cpg_pkg::ADR_CTRL, 8'h00);
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        wrap_up;
    end
endmodule // tb_cascaded_pulse_gen_warmup_timer
`default_nettype wire
